// >>> mist_defs.vh
// Purpose: Constants for the interrupt source and time base block
// Assumes: Word-aligned Avalon-MM register map, 32-bit data
// Notes:   Flag vector order is also the service priority order
//
// Function
// - Pin edge of chosen type sets pin flag
// - Vector only with global, own enable, stack room
// - Pin service clears its flag and global enable
// - Edge select: rising, falling, both, or off
// - Pull-high selection stays active on interrupt pins
// - Comparator output change sets its flag
// - Comparator service clears flag and global enable
// - Four grouped interrupts built from subordinate sources
// - Subordinate flag set sets group flag; serial only when enabled
// - Group service clears group flag, global only
// - Conversion finish sets converter-done flag
// - Converter service clears its flag, global enable
// - Divider overflow sets time base flag
// - Time base service clears flag, global enable
// - One bit runs or stops both time bases
// - Clock select: dedicated clock or system/4
// - Time base 1 period 4096 to 32768
// - Time base 0 period 256 doubling to 32768
// - Serial byte done sets serial module flag
// - Serial flag cleared by software only
// - Any flag rising edge produces wake-up
`ifndef MIST_DEFS_VH
`define MIST_DEFS_VH

// Register word addresses
`define MIST_OFS_CTRL      4'h0
`define MIST_OFS_FLAGS     4'h1
`define MIST_OFS_ENABLES   4'h2
`define MIST_OFS_EDGE      4'h3
`define MIST_OFS_TBC       4'h4
`define MIST_OFS_SERIAL    4'h5
`define MIST_OFS_PULLUP    4'h6
`define MIST_OFS_STATUS    4'h7

// Reset values
`define MIST_TBC_RESET     8'h37
`define MIST_EDGE_RESET    8'h00

// Time base control fields
`define MIST_TBC_RUN       7
`define MIST_TBC_CKSEL     6
`define MIST_TBC_TB1_HI    5
`define MIST_TBC_TB1_LO    4
`define MIST_TBC_LOWPWR    3
`define MIST_TBC_TB0_HI    2
`define MIST_TBC_TB0_LO    0
`define MIST_TB0_BASE      15'h00ff
`define MIST_TB1_BASE      15'h0fff
`define MIST_SYSDIV        2'h3

// Edge select codes
`define MIST_EDGE_OFF      2'h0
`define MIST_EDGE_RISE     2'h1
`define MIST_EDGE_FALL     2'h2
`define MIST_EDGE_BOTH     2'h3

// Source positions in the flag vector, priority order
`define MIST_NSRC          13
`define MIST_SRC_EXT0      0
`define MIST_SRC_CMP0      4
`define MIST_SRC_GRP0      6
`define MIST_SRC_ADC       10
`define MIST_SRC_TB0       11
`define MIST_SRC_TB1       12
`define MIST_SERIAL_GROUP  1

`endif

// >>> mist_irq_sources.v
// Purpose: Interrupt request flags, priority and time bases
// Assumes: All inputs synchronous except pins, comparators and time base clock
// Notes:   Core acknowledges the offered vector with a pulse
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "mist_defs.vh"

module mist_irq_sources #(
    parameter NPIN = 4,              // External pins
    parameter NGRP = 4               // Grouped interrupts
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        resetn_i,
    // Avalon-MM slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Pins and peripheral events
    input  wire [3:0]  ext_irq_pins_i,
    input  wire [1:0]  cmp_out_i,
    input  wire        conv_done_i,
    input  wire        serial_byte_done_i,
    input  wire [3:0]  group_sub_set_i,
    input  wire        tbase_clock_i,
    // Processor core
    input  wire        stack_full_i,
    input  wire        irq_ack_i,
    output reg         irq_req_o,
    output reg  [3:0]  irq_vector_o,
    // Power and pad control
    output reg         wakeup_o,
    output reg  [3:0]  pin_pullup_o,
    output reg         low_osc_low_power_o
);

    localparam NS = `MIST_NSRC;

    // Software state
    reg              global_irq_enable;   // Core gate
    reg  [NS-1:0]    flags;               // Request flags
    reg  [NS-1:0]    enables;             // Per-source enables
    reg  [7:0]       edge_select_reg;     // Two bits per pin
    reg  [7:0]       time_base_control;   // Run, clock, periods
    reg              serial_module_flag;  // Subordinate flag
    reg              serial_module_enable;// Subordinate enable
    reg  [3:0]       pullup_sel;          // Pull-high choice

    // Synchronisers
    reg  [3:0]       pin_s1;              // First stage
    reg  [3:0]       pin_s2;              // Safe level
    reg  [3:0]       pin_prev;            // Last safe level
    reg  [1:0]       cmp_s1;              // First stage
    reg  [1:0]       cmp_s2;              // Safe level
    reg  [1:0]       cmp_prev;            // Last safe level
    reg              tbc_s1;              // First stage
    reg              tbc_s2;              // Safe level
    reg              tbc_prev;            // Last safe level

    // Time base
    reg  [1:0]       sys_div;             // System clock / 4
    reg  [14:0]      tb_count;            // Shared divider chain

    // Bus handling
    wire             bus_req;
    wire             bus_wr;
    reg  [31:0]      next_rdata;

    // Event and service wiring
    reg  [NS-1:0]    set_ev;
    reg  [NS-1:0]    next_flags;
    reg  [NS-1:0]    ack_clr;
    wire [NS-1:0]    pend;
    reg  [3:0]       next_vec;
    wire             tb_tick;
    wire [14:0]      tb0_mask;
    wire [14:0]      tb1_mask;
    wire             tb0_hit;
    wire             tb1_hit;
    wire [3:0]       pin_rise;
    wire [3:0]       pin_fall;
    reg  [3:0]       pin_hit;
    wire             serial_set;
    integer          i;                   // Pin loop index
    integer          j;                   // Priority loop index

    // A request is taken when the slave drops waitrequest
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_wr  = avs_write_i & ~avs_waitrequest_o;

    // Bus slave: one wait cycle, then answer for one cycle
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
        end else if (bus_req && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= next_rdata;
        end else begin
            avs_waitrequest_o <= 1'b1;   // Back to idle
        end
    end

    // Read mux; unmapped addresses read as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            `MIST_OFS_CTRL:    next_rdata[0] = global_irq_enable;
            `MIST_OFS_FLAGS:   next_rdata[NS-1:0] = flags;
            `MIST_OFS_ENABLES: next_rdata[NS-1:0] = enables;
            `MIST_OFS_EDGE:    next_rdata[7:0] = edge_select_reg;
            `MIST_OFS_TBC:     next_rdata[7:0] = time_base_control;
            `MIST_OFS_SERIAL: begin
                next_rdata[0] = serial_module_flag;
                next_rdata[1] = serial_module_enable;
            end
            `MIST_OFS_PULLUP:  next_rdata[3:0] = pullup_sel;
            `MIST_OFS_STATUS: begin
                next_rdata[3:0] = pin_s2;
                next_rdata[5:4] = cmp_s2;
                next_rdata[6]   = stack_full_i;
                next_rdata[7]   = irq_req_o;
                next_rdata[11:8] = irq_vector_o;
            end
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // Pin and comparator synchronisers
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1   <= 4'h0;
            pin_s2   <= 4'h0;
            pin_prev <= 4'h0;
            cmp_s1   <= 2'h0;
            cmp_s2   <= 2'h0;
            cmp_prev <= 2'h0;
            tbc_s1   <= 1'b0;
            tbc_s2   <= 1'b0;
            tbc_prev <= 1'b0;
        end else begin
            pin_s1   <= ext_irq_pins_i;
            pin_s2   <= pin_s1;
            pin_prev <= pin_s2;
            cmp_s1   <= cmp_out_i;
            cmp_s2   <= cmp_s1;
            cmp_prev <= cmp_s2;
            tbc_s1   <= tbase_clock_i;
            tbc_s2   <= tbc_s1;
            tbc_prev <= tbc_s2;
        end
    end

    // Edges are taken from the second stage only
    assign pin_rise = pin_s2 & ~pin_prev;
    assign pin_fall = ~pin_s2 & pin_prev;

    // Edge type per pin; code zero turns the pin off
    always @* begin
        for (i = 0; i < NPIN; i = i + 1) begin
            case (edge_select_reg[2*i +: 2])
                `MIST_EDGE_RISE: pin_hit[i] = pin_rise[i];
                `MIST_EDGE_FALL: pin_hit[i] = pin_fall[i];
                `MIST_EDGE_BOTH: pin_hit[i] = pin_rise[i] |
                                              pin_fall[i];
                default:         pin_hit[i] = 1'b0;
            endcase
        end
    end

    // Time base input: dedicated clock edge or system / 4
    assign tb_tick =
        time_base_control[`MIST_TBC_CKSEL] ?
        (sys_div == `MIST_SYSDIV) :
        (tbc_s2 & ~tbc_prev);

    // Divider masks; period doubles per code step
    assign tb0_mask = ((`MIST_TB0_BASE + 15'h0001) <<
        time_base_control[`MIST_TBC_TB0_HI:`MIST_TBC_TB0_LO])
        - 15'h0001;
    assign tb1_mask = ((`MIST_TB1_BASE + 15'h0001) <<
        time_base_control[`MIST_TBC_TB1_HI:`MIST_TBC_TB1_LO])
        - 15'h0001;
    assign tb0_hit = tb_tick & time_base_control[`MIST_TBC_RUN] &
                     ((tb_count & tb0_mask) == tb0_mask);
    assign tb1_hit = tb_tick & time_base_control[`MIST_TBC_RUN] &
                     ((tb_count & tb1_mask) == tb1_mask);

    // Shared divider; stopping both bases also clears it
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_div  <= 2'h0;
            tb_count <= 15'h0000;
        end else begin
            sys_div <= sys_div + 2'h1;
            if (!time_base_control[`MIST_TBC_RUN])
                tb_count <= 15'h0000;
            else if (tb_tick)
                tb_count <= tb_count + 15'h0001;
        end
    end

    // Serial byte events feed their group when enabled
    assign serial_set = serial_byte_done_i & serial_module_enable;

    // Hardware set events for every flag
    always @* begin
        set_ev = {NS{1'b0}};
        set_ev[`MIST_SRC_EXT0 +: 4] = pin_hit;
        set_ev[`MIST_SRC_CMP0 +: 2] = cmp_s2 ^ cmp_prev;
        set_ev[`MIST_SRC_GRP0 +: 4] = group_sub_set_i;
        set_ev[`MIST_SRC_GRP0 + `MIST_SERIAL_GROUP] =
            group_sub_set_i[`MIST_SERIAL_GROUP] | serial_set;
        set_ev[`MIST_SRC_ADC] = conv_done_i;
        set_ev[`MIST_SRC_TB0] = tb0_hit;
        set_ev[`MIST_SRC_TB1] = tb1_hit;
    end

    // Service clears only the flag of the taken vector
    always @* begin
        ack_clr = {NS{1'b0}};
        if (irq_ack_i && irq_req_o)
            ack_clr[irq_vector_o] = 1'b1;
    end

    // Next flags: software write, service clear, set wins
    always @* begin
        next_flags = flags;
        if (bus_wr && avs_address_i == `MIST_OFS_FLAGS &&
            avs_byteenable_i[0] && avs_byteenable_i[1])
            next_flags = avs_writedata_i[NS-1:0];
        next_flags = (next_flags & ~ack_clr) | set_ev;
    end

    // Pending requests qualified by all gates
    assign pend = flags & enables &
                  {NS{global_irq_enable & ~stack_full_i}};

    // Lowest index has the highest priority
    always @* begin
        next_vec = 4'h0;
        for (j = NS - 1; j >= 0; j = j - 1) begin
            if (pend[j])
                next_vec = j[3:0];
        end
    end

    // Flags and serial subordinate flag
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags              <= {NS{1'b0}};
            serial_module_flag <= 1'b0;
        end else begin
            flags <= next_flags;
            if (serial_byte_done_i)
                serial_module_flag <= 1'b1;
            else if (bus_wr && avs_address_i == `MIST_OFS_SERIAL &&
                     avs_byteenable_i[0])
                serial_module_flag <= avs_writedata_i[0];
        end
    end

    // Software control registers
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            global_irq_enable    <= 1'b0;
            enables              <= {NS{1'b0}};
            edge_select_reg      <= `MIST_EDGE_RESET;
            time_base_control    <= `MIST_TBC_RESET;
            serial_module_enable <= 1'b0;
            pullup_sel           <= 4'h0;
        end else begin
            // Service blocks nesting until software re-enables
            if (irq_ack_i && irq_req_o)
                global_irq_enable <= 1'b0;
            else if (bus_wr && avs_address_i == `MIST_OFS_CTRL &&
                     avs_byteenable_i[0])
                global_irq_enable <= avs_writedata_i[0];
            if (bus_wr && avs_address_i == `MIST_OFS_ENABLES &&
                avs_byteenable_i[0] && avs_byteenable_i[1])
                enables <= avs_writedata_i[NS-1:0];
            if (bus_wr && avs_address_i == `MIST_OFS_EDGE &&
                avs_byteenable_i[0])
                edge_select_reg <= avs_writedata_i[7:0];
            if (bus_wr && avs_address_i == `MIST_OFS_TBC &&
                avs_byteenable_i[0])
                time_base_control <= avs_writedata_i[7:0];
            if (bus_wr && avs_address_i == `MIST_OFS_SERIAL &&
                avs_byteenable_i[0])
                serial_module_enable <= avs_writedata_i[1];
            if (bus_wr && avs_address_i == `MIST_OFS_PULLUP &&
                avs_byteenable_i[0])
                pullup_sel <= avs_writedata_i[3:0];
        end
    end

    // Core request; dropped on acknowledge to avoid a double take
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= 4'h0;
        end else if (irq_ack_i && irq_req_o) begin
            irq_req_o <= 1'b0;
        end else begin
            irq_req_o    <= |pend;
            irq_vector_o <= next_vec;
        end
    end

    // Wake-up on any flag rising, enables ignored
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i)
            wakeup_o <= 1'b0;
        else
            // Serial subordinate flag wakes even with its group off
            wakeup_o <= |(next_flags & ~flags) |
                        (serial_byte_done_i & ~serial_module_flag);
    end

    // Pad controls; pull-high kept whatever the pin's use
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_pullup_o        <= 4'h0;
            low_osc_low_power_o <= 1'b0;
        end else begin
            pin_pullup_o        <= pullup_sel;
            low_osc_low_power_o <=
                time_base_control[`MIST_TBC_LOWPWR];
        end
    end

endmodule // mist_irq_sources

// >>> mist_irq_sources_properties.sv
// Purpose: Port-level checks of the interrupt source block
// Assumes: One clock domain, reset active low
// Notes:   Gate lag of one cycle after any input change
`timescale 1ns/100ps
module mist_irq_props #(
    parameter NPIN = 4,                // External pins
    parameter NGRP = 4                 // Grouped interrupts
) (
    // Clock and reset
    input wire       clock_i,
    input wire       resetn_i,
    // Bus and core
    input wire       avs_read_i,
    input wire       avs_write_i,
    input wire       avs_waitrequest_o,
    input wire       stack_full_i,
    input wire       irq_ack_i,
    input wire       irq_req_o,
    input wire [3:0] irq_vector_o,
    // Power and pads
    input wire       wakeup_o,
    input wire [3:0] pin_pullup_o,
    input wire       low_osc_low_power_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    // A full stack blocks any request
    AST_REQ_STACK: assert property ($past(stack_full_i) |-> !irq_req_o)
        else $error("request while stack full");
    // Service drops the request at once
    AST_ACK_DROP: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
        else $error("request kept after ack");
    // Global enable cleared: no request for two cycles after service
    AST_ACK_HOLD: assert property (irq_ack_i && irq_req_o |=> !irq_req_o [*2])
        else $error("request back too soon");
    // A pending request only falls for a cause
    AST_REQ_FALL: assert property ($fell(irq_req_o) |-> $past(irq_ack_i)
        || $past(stack_full_i) || $past(avs_write_i, 2)
        || $past(avs_write_i, 3))
        else $error("request lost without cause");
    // Only known sources are offered
    AST_VEC_RANGE: assert property (irq_req_o |-> irq_vector_o <= 4'hc)
        else $error("vector out of range");
    // Pull-high follows software only, not pin use
    AST_PULLUP: assert property ($changed(pin_pullup_o)
        |-> $past(avs_write_i && !avs_waitrequest_o, 2))
        else $error("pullup changed without write");
    // Low power bit changes only by a write
    AST_LOWPWR: assert property ($changed(low_osc_low_power_o)
        |-> $past(avs_write_i && !avs_waitrequest_o, 2))
        else $error("low power bit changed without write");
    // Slave answers one cycle after a request
    AST_WAIT_ANSWER: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest late");
    // Answer stands one cycle only
    AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");

    // Main scenarios
    COV_SERVICE: cover property (irq_req_o && irq_ack_i);
    COV_WAKE: cover property (wakeup_o);
    COV_FULL: cover property (stack_full_i && !irq_req_o);
endmodule // mist_irq_props

bind mist_irq_sources mist_irq_props #(.NPIN(NPIN), .NGRP(NGRP)) mist_irq_props_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .wakeup_o(wakeup_o), .pin_pullup_o(pin_pullup_o),
    .low_osc_low_power_o(low_osc_low_power_o));

// >>> mist_core_model.sv
// Purpose: Behavioural core sequencer taking offered vectors
// Assumes: Ack is a one-cycle pulse while the request stands
// Notes:   Delay input lets the bench make the core slow
`timescale 1ns/100ps
module mist_core_model (
    // Clock and reset
    input  wire       clock_i,
    input  wire       resetn_i,
    // Bench controls
    input  wire       full_i,          // Stack has no room
    input  wire [3:0] delay_i,         // Wait before taking
    // Block side
    input  wire       irq_req_i,
    input  wire [3:0] irq_vector_i,
    output wire       stack_full_o,
    output reg        irq_ack_o,
    output reg  [3:0] taken_o,         // Last vector taken
    output reg  [7:0] n_taken_o        // Vectors taken
);
    reg [3:0] wait_cnt;                // Cycles waited so far

    // Full stack reported straight through
    assign stack_full_o = full_i;

    // Take a vector only while offered and room left
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_ack_o <= 1'b0;
            wait_cnt  <= 4'h0;
            taken_o   <= 4'h0;
            n_taken_o <= 8'h00;
        end else begin
            irq_ack_o <= 1'b0;
            if (irq_req_i && !irq_ack_o && !full_i) begin
                if (wait_cnt == delay_i) begin
                    irq_ack_o <= 1'b1;
                    taken_o   <= irq_vector_i;
                    n_taken_o <= n_taken_o + 8'h01;
                    wait_cnt  <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;      // Restart wait on loss
            end
        end
    end
endmodule // mist_core_model

// >>> mist_irq_sources_tb.sv
// Purpose: Self-checking bench of the interrupt source block
// Assumes: Avalon-MM master, core model on the far side
// Notes:   Dedicated time base clock is system clock / 16
`timescale 1ns/100ps
`include "mist_defs.vh"
module mist_irq_sources_tb;
    reg         clk = 0, rstn = 0, rd = 0, wr = 0;
    reg  [3:0]  adr = 0, pins = 0, grp = 0, dly = 0;
    reg  [31:0] wdat = 0, d;
    reg  [1:0]  cmp = 0;
    reg  [2:0]  tdiv = 0;              // Dedicated clock divider
    reg         conv = 0, ser = 0, tbclk = 0, full = 0;
    wire [31:0] rdat;
    wire        wreq, sfull, ack, req, wake, lowp;
    wire [3:0]  vec, pull, tvec;
    wire [7:0]  ntak;
    integer     n_mismatch = 0, checks_done = 0, n_wake = 0, p, c, w0;

    mist_irq_sources mist_irq_sources_i (.clock_i(clk), .resetn_i(rstn),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .ext_irq_pins_i(pins), .cmp_out_i(cmp), .conv_done_i(conv),
        .serial_byte_done_i(ser), .group_sub_set_i(grp),
        .tbase_clock_i(tbclk), .stack_full_i(sfull), .irq_ack_i(ack),
        .irq_req_o(req), .irq_vector_o(vec), .wakeup_o(wake),
        .pin_pullup_o(pull), .low_osc_low_power_o(lowp));
    mist_core_model mist_core_model_i (.clock_i(clk), .resetn_i(rstn),
        .full_i(full), .delay_i(dly), .irq_req_i(req), .irq_vector_i(vec),
        .stack_full_o(sfull), .irq_ack_o(ack), .taken_o(tvec),
        .n_taken_o(ntak));

    initial forever #10 clk = ~clk;
    // Slow dedicated clock, unrelated to bus traffic
    always @(posedge clk) begin
        tdiv <= tdiv + 3'h1;
        if (tdiv == 3'h7) tbclk <= ~tbclk;
        if (wake === 1'b1) n_wake = n_wake + 1;
    end

    task test_done; begin
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    end endtask
    task cmpw(input string nm, input [31:0] e, input [31:0] g); begin
        checks_done = checks_done + 1;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            n_mismatch = n_mismatch + 1;
        end
    end endtask
    // One bus cycle; answer taken at the edge waitrequest is low
    task bus(input w, input [3:0] a, input [31:0] v); integer k; begin
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wdat <= v; k = 0;
        @(posedge clk);
        while (wreq !== 1'b0 && k < 50) begin @(posedge clk); k = k + 1; end
        d = rdat;
        rd <= 0; wr <= 0;
        if (k >= 50) n_mismatch = n_mismatch + 1;
    end endtask
    task wrr(input [3:0] a, input [31:0] v); bus(1, a, v); endtask
    task rdc(input string nm, input [3:0] a, input [31:0] e); begin
        bus(0, a, 0); cmpw(nm, e, d);
    end endtask
    task waitc(input integer n); repeat (n) @(posedge clk); endtask
    task take(input integer e); integer k; begin
        k = 0;
        while (ntak !== e && k < 100) begin @(posedge clk); k = k + 1; end
        cmpw("taken", e, {24'h0, ntak});
    end endtask

    task t_reset; begin
        rdc("tbc", `MIST_OFS_TBC, 32'h37);
        rdc("ctrl", `MIST_OFS_CTRL, 0);
        rdc("edge", `MIST_OFS_EDGE, 0);
        wrr(4'h9, 32'hff);
        rdc("unmapped", 4'h9, 0);
        $display("test reset done");
    end endtask
    task t_pins; begin
        wrr(`MIST_OFS_PULLUP, 32'h5);
        for (p = 0; p < 4; p = p + 1) for (c = 0; c < 4; c = c + 1) begin
            wrr(`MIST_OFS_EDGE, c << (2 * p));
            wrr(`MIST_OFS_FLAGS, 0);
            pins[p] <= 1'b1; waitc(6);
            rdc("rise", `MIST_OFS_FLAGS, (c & 1) << p);
            wrr(`MIST_OFS_FLAGS, 0);
            rdc("once", `MIST_OFS_FLAGS, 0);
            pins[p] <= 1'b0; waitc(6);
            rdc("fall", `MIST_OFS_FLAGS, ((c >> 1) & 1) << p);
        end
        cmpw("pullup", 5, {28'h0, pull});
        wrr(`MIST_OFS_EDGE, 0); wrr(`MIST_OFS_FLAGS, 0);
        $display("test pins done");
    end endtask
    task t_service; begin
        wrr(`MIST_OFS_EDGE, 32'h10);
        wrr(`MIST_OFS_ENABLES, 32'h4);
        full <= 1'b1; pins[2] <= 1'b1; waitc(10);
        cmpw("no global", 0, {24'h0, ntak});
        wrr(`MIST_OFS_CTRL, 1); waitc(10);
        cmpw("stack full", 0, {24'h0, ntak});
        full <= 1'b0; take(1);
        cmpw("vector", 2, {28'h0, tvec});
        rdc("pin clr", `MIST_OFS_FLAGS, 0);
        rdc("gie clr", `MIST_OFS_CTRL, 0);
        pins[2] <= 1'b0;
        $display("test service done");
    end endtask
    task t_prio; begin
        wrr(`MIST_OFS_ENABLES, 32'h410); dly <= 3;
        conv <= 1'b1; cmp <= 2'b01;
        @(posedge clk) conv <= 1'b0;
        waitc(6); wrr(`MIST_OFS_CTRL, 1); take(2);
        cmpw("first", `MIST_SRC_CMP0, {28'h0, tvec});
        rdc("pending", `MIST_OFS_FLAGS, 32'h400);
        wrr(`MIST_OFS_CTRL, 1); take(3);
        cmpw("second", `MIST_SRC_ADC, {28'h0, tvec});
        rdc("adc clr", `MIST_OFS_FLAGS, 0);
        rdc("gie clr", `MIST_OFS_CTRL, 0);
        cmp <= 2'b00; waitc(6);
        rdc("cmp fall", `MIST_OFS_FLAGS, 32'h10);
        wrr(`MIST_OFS_FLAGS, 0);
        $display("test priority done");
    end endtask
    task t_group; begin
        wrr(`MIST_OFS_SERIAL, 2); wrr(`MIST_OFS_ENABLES, 32'h80); w0 = n_wake;
        ser <= 1'b1;
        @(posedge clk) ser <= 1'b0;
        waitc(3);
        rdc("serial", `MIST_OFS_SERIAL, 3);
        rdc("group1", `MIST_OFS_FLAGS, 32'h80);
        cmpw("wake", w0 + 1, n_wake);
        wrr(`MIST_OFS_CTRL, 1); take(4);
        cmpw("grp vec", 7, {28'h0, tvec});
        rdc("grp clr", `MIST_OFS_FLAGS, 0);
        rdc("ser kept", `MIST_OFS_SERIAL, 3);
        wrr(`MIST_OFS_SERIAL, 2);
        rdc("ser clr", `MIST_OFS_SERIAL, 2);
        grp <= 4'h8;
        @(posedge clk) grp <= 4'h0;
        waitc(3);
        rdc("group3", `MIST_OFS_FLAGS, 32'h200);
        cmpw("wake off", w0 + 2, n_wake);
        wrr(`MIST_OFS_FLAGS, 0);
        $display("test group done");
    end endtask
    task t_tbase; begin
        wrr(`MIST_OFS_TBC, 32'h48); waitc(2);
        cmpw("low power", 1, {31'h0, lowp});
        wrr(`MIST_OFS_FLAGS, 0); waitc(1100);
        rdc("tb off", `MIST_OFS_FLAGS, 0);
        wrr(`MIST_OFS_TBC, 32'hc1); waitc(1990);
        rdc("tb0 early", `MIST_OFS_FLAGS, 0);
        waitc(60);
        rdc("tb0", `MIST_OFS_FLAGS, 32'h800);
        waitc(14200); bus(0, `MIST_OFS_FLAGS, 0);
        cmpw("tb1 early", 0, d & 32'h1000);
        waitc(400); bus(0, `MIST_OFS_FLAGS, 0);
        cmpw("tb1", 32'h1000, d & 32'h1000);
        wrr(`MIST_OFS_TBC, 0); wrr(`MIST_OFS_FLAGS, 0);
        wrr(`MIST_OFS_TBC, 32'h80); waitc(3900);
        rdc("ded early", `MIST_OFS_FLAGS, 0);
        waitc(400);
        rdc("ded", `MIST_OFS_FLAGS, 32'h800);
        $display("test time base done");
    end endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset; t_pins; t_service; t_prio; t_group; t_tbase;
        test_done;
    end
    // Tests need about 23000 cycles
    initial begin
        repeat (45000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        test_done;
    end
endmodule // mist_irq_sources_tb
